// ===== core/ppc_pkg.sv
package ppc_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  // Control field positions.
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int CTRL_SWITCH_DISABLE_BIT = 1;
  localparam int CTRL_TEMP_PROFILE_BIT = 2;
  // Mode value that requests reverse mode.
  localparam logic [3:0] MODE_REVERSE = 4'ha;
  // Reset values.
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] MASK_RESET = 2'h3;
  // Charge detail status codes.
  localparam logic [3:0] DETAIL_CHARGING = 4'h0;
  localparam logic [3:0] DETAIL_TEMP_SUSPEND = 4'h1;
  localparam logic [3:0] DETAIL_NO_BATTERY = 4'h2;
  localparam logic [3:0] DETAIL_NOT_CHARGING = 4'h3;
  // Interrupt status bit positions.
  localparam int IRQ_CHARGER = 0;
  localparam int IRQ_SHIP = 1;
  // Thermistor condition states.
  typedef enum logic [3:0] {
    THERM_NORMAL = 4'b0001,
    THERM_SUSPEND = 4'b0010,
    THERM_REMOVED = 4'b0100,
    THERM_OFF = 4'b1000
  } ppc_therm_e;
endpackage

// ===== core/ppc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change is accepted once stages two and three agree.
module ppc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] s1Reg;
  logic [WIDTH-1:0] s2Reg;
  logic [WIDTH-1:0] s3Reg;

  // Per-bit chain and agreement filter.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          s1Reg[i] <= 1'b0;
          s2Reg[i] <= 1'b0;
          s3Reg[i] <= 1'b0;
          synced[i] <= 1'b0;
        end else begin
          s1Reg[i] <= async[i];
          s2Reg[i] <= s1Reg[i];
          s3Reg[i] <= s2Reg[i];
          if (s2Reg[i] == s3Reg[i]) begin
            synced[i] <= s3Reg[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== core/ppc_power_path.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Both standby controls inactive: converter follows the power-path state machine.
// - Switch disable pin or bit, outside reverse mode, turns battery switch off and stops charging.
// - Reverse pin or mode 0xA: switch on, converter machine-controlled, no ship mode even with standby pin high.
// - Standby bit only, switch allowed: keep switch on, converter off.
// - Standby pin high: valid input disables converter; invalid input enters ship mode.
// - Switch disabled: converter machine-controlled only when both standby controls inactive.
// - Too cold or too hot: stop charging and reset charge timers.
// - Temperature suspension updates detail status, charge-ok and sets charger interrupt.
// - Temperature back in range: resume charging and restart charge timer.
// - Temperature-zone charging only while temperature-profile enable bit is one.
// - Thermistor tied to supply rail: battery removed, no charging.
// - Thermistor grounded: monitoring off, battery assumed, charge on valid input.
// - Reverse pin low: reverse decision comes from the register interface.
module ppc_power_path (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic standbyPin,
  input wire logic batterySwitchDisablePin,
  input wire logic reverseModeEnablePin,
  input wire logic inputSourceValid,
  input wire logic thermCold,
  input wire logic thermHot,
  input wire logic thermGrounded,
  input wire logic thermTiedToRail,
  input wire logic machineBatterySwitchOn,
  input wire logic machineConverterOn,
  output logic batterySwitchOn,
  output logic converterOn,
  output logic chargeEnable,
  output logic chargeTimerReset,
  output logic tempProfileActive,
  output logic shipMode,
  output logic interrupt
);
  logic [3:0] modeReg;
  logic [2:0] ctrlReg;
  logic [1:0] irqReg;
  logic [1:0] maskReg;
  logic [3:0] detailReg;
  logic chargeOkReg;
  logic shipReg;
  logic standbyS;
  logic switchDisableS;
  logic reverseS;
  logic inputValidS;
  logic coldS;
  logic hotS;
  logic groundedS;
  logic railS;
  ppc_pkg::ppc_therm_e thermReg;
  ppc_pkg::ppc_therm_e thermNext;
  logic standbyBit;
  logic switchDisableBit;
  logic reverseOn;
  logic switchDisabled;
  logic shipNext;
  logic chargerEvent;
  logic shipEvent;

  // Pin and comparator inputs cross into the clock domain.
  ppc_sync #(.WIDTH(8)) u_sync (
    .clk(clk),
    .reset(reset),
    .async({thermTiedToRail, thermGrounded, thermHot, thermCold, inputSourceValid,
            reverseModeEnablePin, batterySwitchDisablePin, standbyPin}),
    .synced({railS, groundedS, hotS, coldS, inputValidS, reverseS, switchDisableS, standbyS})
  );
  assign standbyBit = ctrlReg[ppc_pkg::CTRL_STANDBY_BIT];
  assign switchDisableBit = ctrlReg[ppc_pkg::CTRL_SWITCH_DISABLE_BIT];

  // Reverse request: pin high wins, otherwise the mode field decides.
  assign reverseOn = reverseS || (modeReg == ppc_pkg::MODE_REVERSE);
  assign switchDisabled = switchDisableS || switchDisableBit;

  // Ship mode: standby pin high with no valid input, outside reverse mode.
  assign shipNext = !reverseOn && standbyS && !inputValidS;

  // Thermistor condition, grounded first so monitoring can be switched off.
  always_comb begin
    if (groundedS) begin
      thermNext = ppc_pkg::THERM_OFF;
    end else if (railS) begin
      thermNext = ppc_pkg::THERM_REMOVED;
    end else if (coldS || hotS) begin
      thermNext = ppc_pkg::THERM_SUSPEND;
    end else begin
      thermNext = ppc_pkg::THERM_NORMAL;
    end
  end

  // Registered thermistor state.
  always_ff @(posedge clk) begin
    if (reset) begin
      thermReg <= ppc_pkg::THERM_NORMAL;
    end else begin
      thermReg <= thermNext;
    end
  end

  // Ship mode register.
  always_ff @(posedge clk) begin
    if (reset) begin
      shipReg <= 1'b0;
    end else begin
      shipReg <= shipNext;
    end
  end

  // Battery switch and converter decision.
  always_ff @(posedge clk) begin
    if (reset) begin
      batterySwitchOn <= 1'b0;
      converterOn <= 1'b0;
    end else if (shipNext) begin
      batterySwitchOn <= 1'b0;
      converterOn <= 1'b0;
    end else if (reverseOn) begin
      batterySwitchOn <= 1'b1;
      converterOn <= machineConverterOn;
    end else if (switchDisabled) begin
      batterySwitchOn <= 1'b0;
      converterOn <= (!standbyS && !standbyBit) ? machineConverterOn : 1'b0;
    end else if (standbyS) begin
      batterySwitchOn <= 1'b1;
      converterOn <= 1'b0;
    end else if (standbyBit) begin
      batterySwitchOn <= 1'b1;
      converterOn <= 1'b0;
    end else begin
      batterySwitchOn <= machineBatterySwitchOn;
      converterOn <= machineConverterOn;
    end
  end

  // Charge permission, timer reset and temperature profile.
  always_ff @(posedge clk) begin
    if (reset) begin
      chargeEnable <= 1'b0;
      chargeTimerReset <= 1'b1;
      tempProfileActive <= 1'b0;
    end else begin
      chargeEnable <= !shipNext && !reverseOn && !switchDisabled && inputValidS
                      && (thermNext == ppc_pkg::THERM_NORMAL || thermNext == ppc_pkg::THERM_OFF);
      chargeTimerReset <= (thermNext == ppc_pkg::THERM_SUSPEND);
      tempProfileActive <= ctrlReg[ppc_pkg::CTRL_TEMP_PROFILE_BIT] && !groundedS;
    end
  end
  assign shipMode = shipReg;

  // Charge detail and charge-ok status.
  always_ff @(posedge clk) begin
    if (reset) begin
      detailReg <= ppc_pkg::DETAIL_NOT_CHARGING;
      chargeOkReg <= 1'b0;
    end else begin
      case (thermNext)
        ppc_pkg::THERM_SUSPEND: begin
          detailReg <= ppc_pkg::DETAIL_TEMP_SUSPEND;
          chargeOkReg <= 1'b0;
        end
        ppc_pkg::THERM_REMOVED: begin
          detailReg <= ppc_pkg::DETAIL_NO_BATTERY;
          chargeOkReg <= 1'b0;
        end
        default: begin
          detailReg <= inputValidS ? ppc_pkg::DETAIL_CHARGING : ppc_pkg::DETAIL_NOT_CHARGING;
          chargeOkReg <= 1'b1;
        end
      endcase
    end
  end

  // Events: entry to or exit from temperature suspension, and entry to ship mode.
  assign chargerEvent = (thermNext == ppc_pkg::THERM_SUSPEND) != (thermReg == ppc_pkg::THERM_SUSPEND);
  assign shipEvent = shipNext && !shipReg;

  // Software registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      modeReg <= ppc_pkg::MODE_RESET;
      ctrlReg <= ppc_pkg::CTRL_RESET;
      maskReg <= ppc_pkg::MASK_RESET;
    end else if (regWr) begin
      if (regAddr == ppc_pkg::ADDR_MODE) begin
        modeReg <= regWrData[3:0];
      end else if (regAddr == ppc_pkg::ADDR_CTRL) begin
        ctrlReg <= regWrData[2:0];
      end else if (regAddr == ppc_pkg::ADDR_MASK) begin
        maskReg <= regWrData[1:0];
      end
    end
  end

  // Sticky interrupt bits; a new event wins over a write-one clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      irqReg <= 2'h0;
    end else begin
      irqReg[ppc_pkg::IRQ_CHARGER] <= chargerEvent ||
        (irqReg[ppc_pkg::IRQ_CHARGER] && !(regWr && regAddr == ppc_pkg::ADDR_IRQ
                                           && regWrData[ppc_pkg::IRQ_CHARGER]));
      irqReg[ppc_pkg::IRQ_SHIP] <= shipEvent ||
        (irqReg[ppc_pkg::IRQ_SHIP] && !(regWr && regAddr == ppc_pkg::ADDR_IRQ
                                        && regWrData[ppc_pkg::IRQ_SHIP]));
    end
  end
  assign interrupt = |(irqReg & ~maskReg);

  // Read port; unmapped addresses return zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      if (regAddr == ppc_pkg::ADDR_MODE) begin
        regRdData <= {4'h0, modeReg};
      end else if (regAddr == ppc_pkg::ADDR_CTRL) begin
        regRdData <= {5'h00, ctrlReg};
      end else if (regAddr == ppc_pkg::ADDR_STATUS) begin
        regRdData <= {shipReg, chargeOkReg, batterySwitchOn, converterOn, detailReg};
      end else if (regAddr == ppc_pkg::ADDR_IRQ) begin
        regRdData <= {6'h00, irqReg};
      end else if (regAddr == ppc_pkg::ADDR_MASK) begin
        regRdData <= {6'h00, maskReg};
      end else begin
        regRdData <= 8'h00;
      end
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== tb/ppc_power_path_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the power-path block from its ports only.
module ppc_power_path_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic batterySwitchOn,
  input wire logic converterOn,
  input wire logic chargeEnable,
  input wire logic chargeTimerReset,
  input wire logic shipMode,
  input wire logic interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Output relations, register effects and read timing.
  a_ship_all_off: assert property (shipMode |-> !batterySwitchOn && !converterOn)
    else $error("ship mode with outputs on");
  a_charge_not_ship: assert property (chargeEnable |-> !shipMode)
    else $error("charging in ship mode");
  a_standby_bit_off: assert property (regWr && regAddr == 4'h1 && regWrData[0] |-> ##[1:3] !converterOn)
    else $error("converter stays on with standby bit");
  a_reverse_switch_on: assert property (regWr && regAddr == 4'h0 && regWrData[3:0] == 4'ha |-> ##[1:3] batterySwitchOn)
    else $error("reverse mode without battery switch");
  a_disable_stops_charge: assert property (regWr && regAddr == 4'h1 && regWrData[1] |-> ##[1:3] !chargeEnable)
    else $error("charging with switch disabled");
  a_timer_held_idle: assert property (chargeEnable |-> !chargeTimerReset)
    else $error("timer held while charging");
  a_read_idle_zero: assert property (!regRd || regAddr > 4'h4 |=> regRdData == 8'h00)
    else $error("read data outside read slot");
  a_mode_readback: assert property (regWr && regAddr == 4'h0 ##1 regRd && regAddr == 4'h0
    |=> regRdData[3:0] == $past(regWrData[3:0], 2))
    else $error("mode readback wrong");
  a_reset_state: assert property (disable iff (1'b0) reset |=> chargeTimerReset && !chargeEnable && !interrupt)
    else $error("outputs wrong after reset");
  // Main scenarios reached.
  c_ship: cover property (shipMode);
  c_irq: cover property (interrupt);
  c_suspend: cover property (chargeEnable ##1 !chargeEnable);
endmodule
bind ppc_power_path ppc_power_path_chk ppc_power_path_chk_inst (.*);
`default_nettype wire

// ===== tb/ppc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host and board side: applies requested pin levels just after a clock edge.
module ppc_host_model (
  input wire logic clk,
  input wire logic [9:0] req,
  output logic [9:0] pins
);
  // Pins start low, so a low reverse pin leaves the decision to the registers.
  initial pins = 10'h000;
  // Levels change only right after a rising edge and then hold.
  always @(posedge clk) begin
    pins <= req;
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic [9:0] req = 10'h000;
  logic [9:0] pins;
  logic [7:0] regRdData;
  logic [7:0] v;
  logic batterySwitchOn, converterOn, chargeEnable, chargeTimerReset, tempProfileActive, shipMode, interrupt;
  int errTotal = 0;
  int cmpCount = 0;
  // Rows: pins (mConv mSw rail gnd hot cold valid rev dis standby_pin), mode, ctrl, expected sw conv ship charge.
  logic [20:0] rows [9] = '{{10'h208, 4'h0, 3'h0, 4'b0101}, {10'h308, 4'h0, 3'h1, 4'b1000},
    {10'h209, 4'h0, 3'h0, 4'b1000}, {10'h301, 4'h0, 3'h0, 4'b0010}, {10'h30a, 4'h0, 3'h0, 4'b0100},
    {10'h308, 4'h0, 3'h3, 4'b0000}, {10'h30b, 4'h0, 3'h0, 4'b0000}, {10'h205, 4'h0, 3'h0, 4'b1100},
    {10'h00a, 4'ha, 3'h0, 4'b1000}};
  // Clock at 40 MHz.
  always #12.5 clk = ~clk;
  ppc_host_model ppc_host_model_inst (.clk(clk), .req(req), .pins(pins));
  ppc_power_path ppc_power_path_inst (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .standbyPin(pins[0]),
    .batterySwitchDisablePin(pins[1]), .reverseModeEnablePin(pins[2]), .inputSourceValid(pins[3]),
    .thermCold(pins[4]), .thermHot(pins[5]), .thermGrounded(pins[6]), .thermTiedToRail(pins[7]),
    .machineBatterySwitchOn(pins[8]), .machineConverterOn(pins[9]), .batterySwitchOn(batterySwitchOn),
    .converterOn(converterOn), .chargeEnable(chargeEnable), .chargeTimerReset(chargeTimerReset),
    .tempProfileActive(tempProfileActive), .shipMode(shipMode), .interrupt(interrupt));
  // Counts a comparison and reports a mismatch.
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle launched just after a rising edge.
  task cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWrData <= d;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input logic [3:0] a, output logic [7:0] d);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    #1 d = regRdData;
  endtask
  // Covers pin synchronisation plus the output register, then steps off the edge so outputs have settled.
  task settle;
    repeat (8) cyc(1'b0, 1'b0, 4'h0, 8'h00);
    #1;
  endtask
  task print_verdict;
    if (errTotal == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    wr(4'hf, 8'hff);
    rd(4'hf, v);
    chk(v, 8'h00);
    rd(4'h4, v);
    chk(v, 8'h03);
    rd(4'h1, v);
    chk(v, 8'h00);
    wr(4'h0, 8'h0a);
    rd(4'h0, v);
    chk(v, 8'h0a);
    for (int i = 0; i < 9; i++) begin
      req = rows[i][20:11];
      wr(4'h0, {4'h0, rows[i][10:7]});
      wr(4'h1, {5'h00, rows[i][6:4]});
      settle();
      chk(batterySwitchOn, rows[i][3]);
      chk(converterOn, rows[i][2]);
      chk(shipMode, rows[i][1]);
      if (!rows[i][11] && !rows[i][4]) chk(chargeEnable, rows[i][0]);
    end
    // Temperature suspension, resume, interrupt masking.
    req = 10'h308;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h03);
    settle();
    chk(interrupt, 1'b0);
    req[4] = 1'b1;
    settle();
    chk(chargeEnable, 1'b0);
    chk(chargeTimerReset, 1'b1);
    chk(interrupt, 1'b1);
    rd(4'h2, v);
    chk(v & 8'h4f, 8'h01);
    wr(4'h3, 8'h01);
    settle();
    chk(interrupt, 1'b0);
    req[4] = 1'b0;
    settle();
    chk(chargeEnable, 1'b1);
    chk(chargeTimerReset, 1'b0);
    rd(4'h2, v);
    chk(v & 8'h4f, 8'h40);
    wr(4'h3, 8'h01);
    wr(4'h4, 8'h01);
    req[5] = 1'b1;
    settle();
    chk(chargeEnable, 1'b0);
    chk(interrupt, 1'b0);
    wr(4'h4, 8'h00);
    settle();
    chk(interrupt, 1'b1);
    // Profile enable, grounded and rail-tied thermistor.
    req[5] = 1'b0;
    wr(4'h1, 8'h04);
    settle();
    chk(tempProfileActive, 1'b1);
    req[4] = 1'b1;
    req[6] = 1'b1;
    settle();
    chk(chargeEnable, 1'b1);
    chk(tempProfileActive, 1'b0);
    req[4] = 1'b0;
    req[6] = 1'b0;
    req[7] = 1'b1;
    settle();
    chk(chargeEnable, 1'b0);
    rd(4'h2, v);
    chk(v & 8'h0f, 8'h02);
    req[7] = 1'b0;
    repeat (2) cyc(1'b0, 1'b0, 4'h0, 8'h00);
    #1 chk(chargeEnable, 1'b0);
    settle();
    chk(chargeEnable, 1'b1);
    // Second reset in mid-run.
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 chk(chargeTimerReset, 1'b1);
    chk(chargeEnable, 1'b0);
    chk(interrupt, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
